// ---- logic/sarcs_pkg.sv ----
/*
 * Constants shared by the successive-approximation converter sequencer:
 * register offsets, field positions, reset values, codes and timing counts.
 * Assumes a single 100 MHz system clock from which the converter clock is
 * derived as a one-cycle enable.
 */
package sarcs_pkg;
    // System clock rate and converter clock rate, in hertz.
    localparam int unsigned SARCS_REF_HZ = 100_000_000;
    localparam int unsigned SARCS_ADC_HZ = 12_500_000;
    // System clock cycles per converter clock cycle.
    localparam int unsigned SARCS_DIV = SARCS_REF_HZ / SARCS_ADC_HZ;
    // Power-up calibration length in converter clock cycles.
    localparam int unsigned SARCS_CAL_CYCLES = 3840;
    // Converter cycles spent sampling the input.
    localparam int unsigned SARCS_SAMPLE_CYCLES = 2;
    // Widths of the result, channel and calibration array.
    localparam int unsigned SARCS_RES_W = 12;
    localparam int unsigned SARCS_CH_W = 5;
    localparam int unsigned SARCS_CAL_W = 8;
    // Resolution mode codes.
    localparam logic [1:0] SARCS_MODE_8 = 2'h0;
    localparam logic [1:0] SARCS_MODE_10 = 2'h1;
    localparam logic [1:0] SARCS_MODE_12 = 2'h2;
    // Register byte offsets.
    localparam logic [7:0] SARCS_REG_CTRL = 8'h00;
    localparam logic [7:0] SARCS_REG_STATUS = 8'h04;
    localparam logic [7:0] SARCS_REG_RESULT = 8'h08;
    localparam logic [7:0] SARCS_REG_KELVIN = 8'h0C;
    localparam logic [7:0] SARCS_REG_TEMPMASK = 8'h10;
    localparam logic [7:0] SARCS_REG_IRQ_STAT = 8'h14;
    localparam logic [7:0] SARCS_REG_IRQ_MASK = 8'h18;
    localparam logic [7:0] SARCS_REG_CALCODE = 8'h1C;
    // Status register bit positions.
    localparam int unsigned SARCS_ST_CAL = 0;
    localparam int unsigned SARCS_ST_BUSY = 1;
    localparam int unsigned SARCS_ST_SAMPLE = 2;
    localparam int unsigned SARCS_ST_VALID = 3;
    // Interrupt bit positions.
    localparam int unsigned SARCS_IRQ_CAL_DONE = 0;
    localparam int unsigned SARCS_IRQ_CONV_DONE = 1;
    localparam int unsigned SARCS_IRQ_REFUSED = 2;
    localparam int unsigned SARCS_IRQ_W = 3;
    // Reset values.
    localparam logic [1:0] SARCS_MODE_RST = 2'h2;
    localparam logic [31:0] SARCS_TEMPMASK_RST = 32'h0000_0000;
    localparam logic [7:0] SARCS_CALCODE_RST = 8'h80;
    // Sequencer states.
    typedef enum logic [2:0] {
        SARCS_S_CAL, SARCS_S_IDLE, SARCS_S_SAMPLE, SARCS_S_CONV, SARCS_S_POST
    } sarcs_state_t;
endpackage

// ---- logic/sarcs_top.sv ----
/*
 * Digital sequencer of a successive-approximation converter: power-up
 * calibration, start/sample/busy/result-valid handshake, SAR bit search,
 * post-calibration, result latching, kelvin coding and a register port.
 * Assumes the analog comparator output arrives asynchronously on comp_in,
 * and that start and channel select come from fabric logic on ref_clk_in.
 */
// Function
// - Selectable 8, 10 and 12 bit modes.
// - Result MSB-justified on twelve-bit bus.
// - Five-bit channel select picks one of 32.
// - Calibrate 3840 converter cycles after reset.
// - Eight-bit calibration array holds offset correction.
// - Post-calibrate offset or one bit after conversion.
// - Start raises sample and busy; sample drops.
// - Completion drops busy, raises result valid.
// - Result valid falls at next start.
// - Result held until next result valid.
// - Temperature channels, ten-bit: one kelvin per count.
// - Eight-bit four kelvin; twelve-bit quarter kelvin per count.
`timescale 1ns/1ns
module sarcs_top import sarcs_pkg::*; #(
    // Power-up calibration length in converter cycles; may be shortened.
    parameter int unsigned CAL_CYCLES = SARCS_CAL_CYCLES
) (
    // Clock and resets.
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic converter_reset_in,
    // Conversion request from fabric logic.
    input wire logic conversion_start_pulse_in,
    input wire logic [SARCS_CH_W-1:0] channel_select_in,
    // Handshake and result towards fabric logic.
    output logic sample_out,
    output logic busy_out,
    output logic result_valid_out,
    output logic calibrate_out,
    output logic [SARCS_RES_W-1:0] result_out,
    // Analog front end controls and comparator.
    output logic [SARCS_CH_W-1:0] mux_select_out,
    output logic [SARCS_RES_W-1:0] dac_code_out,
    output logic [SARCS_CAL_W-1:0] cal_code_out,
    output logic [3:0] postcal_target_out,
    input wire logic comp_in,
    // Register port.
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [31:0] reg_rdata_out,
    // Interrupt.
    output logic irq_out
);
    // Width of the calibration counter.
    localparam int unsigned CAL_CNT_W = 12;
    // Calibration counter end value, cast to the counter width.
    localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_CYCLES - 1);
    localparam logic [3:0] DIV_LAST = 4'(SARCS_DIV - 1);
    localparam logic [1:0] SAMPLE_LAST = 2'(SARCS_SAMPLE_CYCLES - 1);

    // Lowest bit position searched for a given mode.
    function automatic logic [3:0] lsb_of(input logic [1:0] mode);
        unique case (mode)
            SARCS_MODE_8: lsb_of = 4'h4;
            SARCS_MODE_10: lsb_of = 4'h2;
            default: lsb_of = 4'h0;
        endcase
    endfunction

    // Converter clock divider and its enable.
    logic [3:0] div_r;
    logic cclk_en;
    // Comparator synchroniser and filtered level.
    logic comp_s1_r, comp_s2_r, comp_s3_r, comp_r;
    // Sequencer state and counters.
    sarcs_state_t state_r;
    logic [CAL_CNT_W-1:0] cal_cnt_r;
    logic [1:0] samp_cnt_r;
    logic [3:0] bit_r;
    logic [3:0] lsb_r;
    logic [1:0] conv_mode_r;
    logic start_pend_r;
    // Search registers and outputs.
    logic [SARCS_RES_W-1:0] sar_r;
    logic [SARCS_RES_W-1:0] result_r;
    logic [SARCS_CH_W-1:0] chan_r;
    logic [SARCS_CAL_W-1:0] cal_code_r;
    logic [3:0] post_sel_r;
    logic valid_r, busy_r, sample_r;
    logic result_is_temp_r;
    // Registers seen by software.
    logic [1:0] mode_r;
    logic [31:0] temp_mask_r;
    logic [SARCS_IRQ_W-1:0] irq_stat_r, irq_mask_r;
    logic [31:0] rdata_r;

    // The converter clock enable ends each divider period.
    assign cclk_en = (div_r == DIV_LAST);

    // Divider producing the converter clock enable.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || converter_reset_in || div_r == DIV_LAST) begin
            div_r <= 4'h0;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end

    // Comparator crossing: the level changes once stages two and three agree.
    always_ff @(posedge ref_clk_in) begin
        comp_s1_r <= comp_in;
        comp_s2_r <= comp_s1_r;
        comp_s3_r <= comp_s2_r;
        if (reset_in) begin
            comp_r <= 1'b0;
        end else if (comp_s2_r == comp_s3_r) begin
            comp_r <= comp_s3_r;
        end
    end

    // Start acceptance and refusal, decided on the system clock.
    wire start_ok = conversion_start_pulse_in && state_r == SARCS_S_IDLE
        && !start_pend_r;
    wire start_refused = conversion_start_pulse_in && !start_ok;
    // Trial bit as a one-hot mask and the searched code with it cleared when the comparator is high.
    wire [SARCS_RES_W-1:0] bit_mask = SARCS_RES_W'(1) << bit_r;
    wire [SARCS_RES_W-1:0] sar_kept = comp_r ? (sar_r & ~bit_mask) : sar_r;
    // Conversion is finishing when the post-calibration tick fires.
    wire conv_done = cclk_en && state_r == SARCS_S_POST;
    wire cal_done = cclk_en && state_r == SARCS_S_CAL
        && cal_cnt_r == CAL_LAST;
    // Post-calibration offset step: comparator high means lower the trim.
    wire post_is_offset = (post_sel_r == 4'h0);
    wire cal_at_min = (cal_code_r == {SARCS_CAL_W{1'b0}});
    wire cal_at_max = (cal_code_r == {SARCS_CAL_W{1'b1}});

    // Pending start, held until the next converter clock tick.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || converter_reset_in) begin
            start_pend_r <= 1'b0;
        end else if (start_ok) begin
            start_pend_r <= 1'b1;
        end else if (cclk_en) begin
            start_pend_r <= 1'b0;
        end
    end

    // Handshake flags: start raises sample and busy, drops valid.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || converter_reset_in) begin
            busy_r <= 1'b0;
            sample_r <= 1'b0;
            valid_r <= 1'b0;
        end else if (start_ok) begin
            busy_r <= 1'b1;
            sample_r <= 1'b1;
            valid_r <= 1'b0;
        end else begin
            if (cclk_en && state_r == SARCS_S_SAMPLE && samp_cnt_r == SAMPLE_LAST) begin
                sample_r <= 1'b0;
            end
            if (conv_done) begin
                busy_r <= 1'b0;
                valid_r <= 1'b1;
            end
        end
    end

    // Sequencer: calibration, sampling, bit search and post-calibration.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || converter_reset_in) begin
            state_r <= SARCS_S_CAL;
            cal_cnt_r <= '0;
            samp_cnt_r <= 2'h0;
            bit_r <= 4'hB;
            lsb_r <= 4'h0;
            conv_mode_r <= SARCS_MODE_RST;
            sar_r <= '0;
            chan_r <= '0;
        end else begin
            if (start_ok) begin
                // Channel and mode are captured with the request.
                chan_r <= channel_select_in;
                conv_mode_r <= mode_r;
                lsb_r <= lsb_of(mode_r);
            end
            if (cclk_en) begin
                unique case (state_r)
                    // Fixed-length power-up calibration.
                    SARCS_S_CAL: begin
                        cal_cnt_r <= cal_cnt_r + 1'b1;
                        if (cal_cnt_r == CAL_LAST) begin
                            state_r <= SARCS_S_IDLE;
                        end
                    end
                    // Waiting for a request.
                    SARCS_S_IDLE: begin
                        if (start_pend_r) begin
                            state_r <= SARCS_S_SAMPLE;
                            samp_cnt_r <= 2'h0;
                        end
                    end
                    // Input tracked, then held.
                    SARCS_S_SAMPLE: begin
                        samp_cnt_r <= samp_cnt_r + 2'h1;
                        if (samp_cnt_r == SAMPLE_LAST) begin
                            state_r <= SARCS_S_CONV;
                            bit_r <= 4'hB;
                            sar_r <= SARCS_RES_W'(1) << 11;
                        end
                    end
                    // One bit decided per converter cycle, MSB first.
                    SARCS_S_CONV: begin
                        if (bit_r == lsb_r) begin
                            sar_r <= sar_kept;
                            state_r <= SARCS_S_POST;
                        end else begin
                            sar_r <= sar_kept | (bit_mask >> 1);
                            bit_r <= bit_r - 4'h1;
                        end
                    end
                    // One post-calibration step closes the conversion.
                    SARCS_S_POST: begin
                        state_r <= SARCS_S_IDLE;
                    end
                endcase
            end
        end
    end

    // Calibration array: power-up search, then drift tracking.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || converter_reset_in) begin
            cal_code_r <= SARCS_CALCODE_RST;
            post_sel_r <= 4'h0;
        end else if (cclk_en && state_r == SARCS_S_CAL && cal_cnt_r < 12'd8) begin
            // First eight calibration cycles trim one trim bit each.
            if (comp_r) begin
                cal_code_r[3'(7 - cal_cnt_r[2:0])] <= 1'b0;
            end
            if (cal_cnt_r[2:0] != 3'h7) begin
                cal_code_r[3'(6 - cal_cnt_r[2:0])] <= 1'b1;
            end
        end else if (conv_done) begin
            // Targets rotate: offset, then each main-array bit in turn.
            post_sel_r <= (post_sel_r == 4'hC) ? 4'h0 : post_sel_r + 4'h1;
            if (post_is_offset && comp_r && !cal_at_min) begin
                cal_code_r <= cal_code_r - 1'b1;
            end else if (post_is_offset && !comp_r && !cal_at_max) begin
                cal_code_r <= cal_code_r + 1'b1;
            end
        end
    end

    // Result latch: changes only as result valid rises.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || converter_reset_in) begin
            result_r <= '0;
            result_is_temp_r <= 1'b0;
        end else if (conv_done) begin
            result_r <= sar_r;
            result_is_temp_r <= temp_mask_r[chan_r];
        end
    end

    // Kelvin coding for temperature channels; zero for other channels.
    logic [11:0] kelvin;
    always_comb begin
        kelvin = 12'h000;
        if (result_is_temp_r) begin
            unique case (conv_mode_r)
                SARCS_MODE_8: kelvin = {2'h0, result_r[11:4], 2'h0};
                SARCS_MODE_10: kelvin = {2'h0, result_r[11:2]};
                default: kelvin = {2'h0, result_r[11:2]};
            endcase
        end
    end

    // Register decode.
    wire wr_ctrl = reg_write_in && reg_addr_in == SARCS_REG_CTRL;
    wire wr_tmask = reg_write_in && reg_addr_in == SARCS_REG_TEMPMASK;
    wire wr_istat = reg_write_in && reg_addr_in == SARCS_REG_IRQ_STAT;
    wire wr_imask = reg_write_in && reg_addr_in == SARCS_REG_IRQ_MASK;
    wire [SARCS_IRQ_W-1:0] irq_events;
    assign irq_events[SARCS_IRQ_CAL_DONE] = cal_done;
    assign irq_events[SARCS_IRQ_CONV_DONE] = conv_done;
    assign irq_events[SARCS_IRQ_REFUSED] = start_refused;
    wire [SARCS_IRQ_W-1:0] irq_clear = wr_istat ? reg_wdata_in[SARCS_IRQ_W-1:0] : '0;
    // Status word for reads.
    wire [31:0] status_word = {28'h0, valid_r, sample_r, busy_r,
        state_r == SARCS_S_CAL};

    // Software registers; a new event wins over its clear.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            mode_r <= SARCS_MODE_RST;
            temp_mask_r <= SARCS_TEMPMASK_RST;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            if (wr_ctrl) begin
                // Mode code 3 is folded to twelve-bit.
                mode_r <= (reg_wdata_in[1:0] == 2'h3) ? SARCS_MODE_12 : reg_wdata_in[1:0];
            end
            if (wr_tmask) begin
                temp_mask_r <= reg_wdata_in;
            end
            if (wr_imask) begin
                irq_mask_r <= reg_wdata_in[SARCS_IRQ_W-1:0];
            end
            irq_stat_r <= (irq_stat_r & ~irq_clear) | irq_events;
        end
    end

    // Read data, present only in the cycle after the read strobe.
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (reg_addr_in)
            SARCS_REG_CTRL: rd_mux = {30'h0, mode_r};
            SARCS_REG_STATUS: rd_mux = status_word;
            SARCS_REG_RESULT: rd_mux = {20'h0, result_r};
            SARCS_REG_KELVIN: rd_mux = {20'h0, kelvin};
            SARCS_REG_TEMPMASK: rd_mux = temp_mask_r;
            SARCS_REG_IRQ_STAT: rd_mux = {29'h0, irq_stat_r};
            SARCS_REG_IRQ_MASK: rd_mux = {29'h0, irq_mask_r};
            SARCS_REG_CALCODE: rd_mux = {24'h0, cal_code_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data register.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || !reg_read_in) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rd_mux;
        end
    end

    // Outputs.
    assign sample_out = sample_r;
    assign busy_out = busy_r;
    assign result_valid_out = valid_r;
    assign calibrate_out = (state_r == SARCS_S_CAL);
    assign result_out = result_r;
    assign mux_select_out = chan_r;
    assign dac_code_out = sar_r;
    assign cal_code_out = cal_code_r;
    assign postcal_target_out = post_sel_r;
    assign reg_rdata_out = rdata_r;
    assign irq_out = |(irq_stat_r & irq_mask_r);
endmodule // sarcs_top

// ---- verification/sarcs_afe_model.sv ----
/* Analog front end model: one fixed level per mux channel and a comparator.
   Assumes the sequencer drives the mux and the trial code from ref_clk_in. */
`timescale 1ns/1ns
module sarcs_afe_model import sarcs_pkg::*; (
    // Channel and trial code from the sequencer.
    input wire logic [SARCS_CH_W-1:0] mux_select_in,
    input wire logic [SARCS_RES_W-1:0] dac_code_in,
    // Comparator answer.
    output logic comp_out
);
    // Each channel has its own level, so a wrong mux shows in the result.
    logic [SARCS_RES_W-1:0] level;
    assign level = {mux_select_in, 7'h35};
    // High when the trial code lies above the selected level.
    assign comp_out = dac_code_in > level;
endmodule // sarcs_afe_model

// ---- verification/sarcs_chk.sv ----
/* Handshake checker for the converter sequencer.
   Assumes it is bound into sarcs_top and sees only its ports. */
`timescale 1ns/1ns
module sarcs_chk import sarcs_pkg::*; #(
    parameter int unsigned CAL_CYCLES = SARCS_CAL_CYCLES
) (
    // Clock and resets.
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic converter_reset_in,
    // Request and handshake.
    input wire logic conversion_start_pulse_in,
    input wire logic [SARCS_CH_W-1:0] channel_select_in,
    input wire logic sample_out,
    input wire logic busy_out,
    input wire logic result_valid_out,
    input wire logic calibrate_out,
    input wire logic [SARCS_RES_W-1:0] result_out,
    input wire logic [SARCS_CH_W-1:0] mux_select_out,
    input wire logic [3:0] postcal_target_out
);
    // Cycles spent calibrating since reset, and cycles of the current busy phase.
    logic [15:0] cal_cnt_r;
    logic [8:0] busy_cnt_r;
    // High in the cycle after a reset edge, so history across reset is ignored.
    logic rst_q_r;
    always_ff @(posedge ref_clk_in) begin
        rst_q_r <= reset_in || converter_reset_in;
        cal_cnt_r <= (reset_in || converter_reset_in) ? 16'h0 : cal_cnt_r + 16'(calibrate_out);
        busy_cnt_r <= busy_out ? busy_cnt_r + 9'h1 : 9'h0;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in || converter_reset_in || rst_q_r);
    // A request that the sequencer must take.
    sequence s_accept;
        conversion_start_pulse_in && !busy_out && !calibrate_out;
    endsequence
    // Sampling lasts at least the first eight cycles.
    sequence s_sampling;
        sample_out [*8];
    endsequence
    start_ack_a: assert property (s_accept |=> busy_out && sample_out)
        else $error("start not answered by busy and sample");
    mux_take_a: assert property (s_accept |=> mux_select_out == $past(channel_select_in))
        else $error("mux channel not taken from request");
    cal_block_a: assert property (calibrate_out && conversion_start_pulse_in |=> !busy_out)
        else $error("start taken during calibration");
    cal_len_a: assert property ($fell(calibrate_out) |->
        cal_cnt_r >= CAL_CYCLES * 8 - 12 && cal_cnt_r <= CAL_CYCLES * 8 + 12)
        else $error("calibration length wrong");
    sample_run_a: assert property ($rose(sample_out) |-> s_sampling ##[1:20] !sample_out)
        else $error("sampling length wrong");
    sample_busy_a: assert property (sample_out |-> busy_out)
        else $error("sample without busy");
    done_len_a: assert property ($fell(busy_out) |->
        result_valid_out && busy_cnt_r >= 9'd70 && busy_cnt_r <= 9'd140)
        else $error("completion wrong");
    busy_valid_a: assert property (!(busy_out && result_valid_out))
        else $error("busy and valid together");
    valid_hold_a: assert property (result_valid_out && !conversion_start_pulse_in
        |=> result_valid_out)
        else $error("valid dropped without start");
    valid_fall_a: assert property (s_accept |=> !result_valid_out)
        else $error("valid kept after start");
    result_hold_a: assert property (!$rose(result_valid_out) |-> $stable(result_out))
        else $error("result changed while held");
    postcal_tgt_a: assert property (postcal_target_out <= 4'hC)
        else $error("post-calibration target out of range");
    postcal_step_a: assert property ($fell(busy_out) |->
        postcal_target_out != $past(postcal_target_out))
        else $error("no post-calibration step after conversion");
endmodule // sarcs_chk
bind sarcs_top sarcs_chk #(.CAL_CYCLES(CAL_CYCLES)) sarcs_chk_i (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .converter_reset_in(converter_reset_in),
    .conversion_start_pulse_in(conversion_start_pulse_in),
    .channel_select_in(channel_select_in), .sample_out(sample_out), .busy_out(busy_out),
    .result_valid_out(result_valid_out), .calibrate_out(calibrate_out),
    .result_out(result_out), .mux_select_out(mux_select_out),
    .postcal_target_out(postcal_target_out)
);

// ---- verification/sarcs_tb_top.sv ----
/* Testbench of the converter sequencer: register tasks, conversions in every mode.
   Assumes the analog front end model answers the comparator. */
`timescale 1ns/1ns
module sarcs_tb_top import sarcs_pkg::*;;
    localparam int unsigned CAL = 20;
    logic ref_clk_in, reset_in, conv_rst, start, comp, wr_en, rd_en;
    logic sample, busy, valid, cal, irq;
    logic [4:0] chan, mux;
    logic [11:0] result, dac;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    int fails, checked;
    sarcs_top #(.CAL_CYCLES(CAL)) sarcs_top_i (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .converter_reset_in(conv_rst),
        .conversion_start_pulse_in(start), .channel_select_in(chan), .sample_out(sample),
        .busy_out(busy), .result_valid_out(valid), .calibrate_out(cal), .result_out(result),
        .mux_select_out(mux), .dac_code_out(dac), .cal_code_out(), .postcal_target_out(),
        .comp_in(comp), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_en),
        .reg_read_in(rd_en), .reg_rdata_out(rdata), .irq_out(irq));
    sarcs_afe_model sarcs_afe_model_i (.mux_select_in(mux), .dac_code_in(dac), .comp_out(comp));
    // Free-running system clock.
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    // Comparison of one value with its expectation.
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic end_of_test;
        $display("checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One write cycle.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk_in);
        wr_en <= 1'b0;
    endtask
    // One read cycle; data stand in the following cycle only.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk_in);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    // A one-cycle start pulse.
    task automatic pulse(input logic [4:0] ch);
        @(posedge ref_clk_in);
        start <= 1'b1;
        chan <= ch;
        @(posedge ref_clk_in);
        start <= 1'b0;
    endtask
    // Bounded wait until neither busy nor calibrating.
    task automatic wait_idle(input int bound, output int n);
        for (n = 0; n < bound && (busy !== 1'b0 || cal !== 1'b0); n++) @(posedge ref_clk_in) #1;
        if (n == bound) begin
            fails++;
            $display("mismatch at %0t: wait timed out", $time);
            end_of_test();
        end
    endtask
    // Full conversion with a refused second start and a kelvin read.
    task automatic conv(input logic [1:0] m, input logic [4:0] ch, input bit temp);
        logic [11:0] lvl;
        logic [31:0] d;
        int n;
        lvl = {ch, 7'h35};
        wr(SARCS_REG_CTRL, {30'h0, m});
        wr(SARCS_REG_TEMPMASK, temp ? 32'h1 << ch : 32'h0);
        pulse(ch);
        #1 cmp_word({29'h0, busy, sample, valid}, 32'h6);
        pulse(ch);
        wait_idle(300, n);
        cmp_word({31'h0, valid}, 32'h1);
        // Status after completion: only the result valid bit stands.
        rd(SARCS_REG_STATUS, d);
        cmp_word(d, 32'h8);
        cmp_word({20'h0, result}, m == SARCS_MODE_8 ? {20'h0, lvl & 12'hFF0} :
            m == SARCS_MODE_10 ? {20'h0, lvl & 12'hFFC} : {20'h0, lvl});
        rd(SARCS_REG_KELVIN, d);
        cmp_word(d, !temp ? 32'h0 : m == SARCS_MODE_8 ? 32'(lvl[11:4]) * 4 :
            32'(lvl[11:2]));
    endtask
    initial begin
        logic [31:0] d;
        int n;
        {reset_in, conv_rst, start, wr_en, rd_en, chan, addr, wdata} = {1'b1, 49'h0};
        fails = 0;
        checked = 0;
        repeat (2) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        pulse(5'h2);
        #1 cmp_word({30'h0, busy, cal}, 32'h1);
        wait_idle(400, n);
        cmp_word(32'(n >= CAL * 8 - 16 && n <= CAL * 8 + 12), 32'h1);
        rd(SARCS_REG_CTRL, d);
        cmp_word(d, 32'h2);
        rd(SARCS_REG_TEMPMASK, d);
        cmp_word(d, 32'h0);
        rd(8'h20, d);
        cmp_word(d, 32'h0);
        // The trial code is zero while calibrating, so the comparator stays low
        // and every trim bit of the calibration array is kept.
        rd(SARCS_REG_CALCODE, d);
        cmp_word(d, 32'hFF);
        $display("test calibration done");
        for (int m = 0; m < 4; m++) conv(2'(m), 5'(3 + m * 9), 1'b1);
        conv(SARCS_MODE_10, 5'h1F, 1'b0);
        $display("test conversions done");
        rd(SARCS_REG_IRQ_STAT, d);
        cmp_word(d, 32'h7);
        cmp_word({31'h0, irq}, 32'h0);
        wr(SARCS_REG_IRQ_MASK, 32'h4);
        @(posedge ref_clk_in) #1 cmp_word({31'h0, irq}, 32'h1);
        wr(SARCS_REG_IRQ_STAT, 32'h7);
        @(posedge ref_clk_in) #1 cmp_word({31'h0, irq}, 32'h0);
        rd(SARCS_REG_IRQ_STAT, d);
        cmp_word(d, 32'h0);
        $display("test interrupts done");
        pulse(5'h7);
        @(posedge ref_clk_in);
        conv_rst <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        conv_rst <= 1'b0;
        #1 cmp_word({29'h0, cal, busy, valid}, 32'h4);
        wait_idle(400, n);
        cmp_word(32'(n >= CAL * 8 - 16 && n <= CAL * 8 + 12), 32'h1);
        conv(SARCS_MODE_12, 5'h11, 1'b1);
        $display("test converter reset done");
        end_of_test();
    end
endmodule // sarcs_tb_top
